// [cth_defs.vh]
// Offsets, reset values and timing counts of the configuration table block
`ifndef CTH_DEFS_VH
`define CTH_DEFS_VH

// ------------------------------
// Table field offsets (byte addresses inside the table window)
// ------------------------------
`define CTH_OFF_SIGNATURE   8'h00
`define CTH_OFF_VERSION     8'h04
`define CTH_OFF_SUPPORTED   8'h08
`define CTH_OFF_ACTIVE      8'h0C
`define CTH_OFF_REQUESTED   8'h10
`define CTH_OFF_CMD_UPPER   8'h14
`define CTH_OFF_DELAY       8'h18
`define CTH_OFF_COUNT       8'h1C
`define CTH_OFF_MAX_OUTST   8'h20

// ------------------------------
// Messaging region offsets
// ------------------------------
`define CTH_OFF_DOORBELL    8'h20
`define CTH_OFF_DB_CLEAR    8'h70
`define CTH_OFF_LOC_SEL     8'hB4
`define CTH_OFF_MEM_OFFSET  8'hB8

// ------------------------------
// Field positions and reset values
// ------------------------------
`define CTH_BIT_READY       0
`define CTH_BIT_SIMPLE      1
`define CTH_BIT_TABLE_DB    0
`define CTH_SEL_CFG_LSB     0
`define CTH_SEL_WID_LSB     16
`define CTH_RST_REQUESTED   32'h00000000
`define CTH_RST_CMD_UPPER   32'h00000000
`define CTH_RST_DELAY       32'h00000000
`define CTH_RST_COUNT       32'h00000001
`define CTH_RST_ACTIVE      32'h00000000

// ------------------------------
// Timing
// ------------------------------
`define CTH_CLK_PERIOD_NS   5
`define CTH_US_NS           1000
`define CTH_CYC_PER_US      (`CTH_US_NS / `CTH_CLK_PERIOD_NS)

`endif

// [cth_doorbell.v]
// Inbound doorbell pending bits with host set and controller clear
`timescale 1ns/10ps
`include "cth_defs.vh"

module cth_doorbell #(
    parameter WIDTH = 32
) (
    input  wire             clk_sys,
    input  wire             resetn,
    input  wire             set_wr,
    input  wire [WIDTH-1:0] set_mask,
    input  wire [WIDTH-1:0] clr_mask,
    output reg  [WIDTH-1:0] pending,
    output reg              ctl_irq
);

    // ------------------------------
    // Per-bit pending flags
    // ------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // R21: host one sets
            // R22: controller one clears, a same-cycle set wins
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    pending[i] <= 1'b0;
                end else if (set_wr && set_mask[i]) begin
                    pending[i] <= 1'b1;
                end else if (clr_mask[i]) begin
                    pending[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------
    // Controller interrupt
    // ------------------------------
    // R21: any pending bit interrupts
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctl_irq <= 1'b0;
        end else begin
            ctl_irq <= |pending;
        end
    end

endmodule

// [cth_coalesce.v]
// Host interrupt coalescing by microsecond delay and event count
`timescale 1ns/10ps
`include "cth_defs.vh"

module cth_coalesce #(
    parameter CYC_PER_US = `CTH_CYC_PER_US
) (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        event_in,
    input  wire [31:0] delay_us,
    input  wire [31:0] count,
    output reg         host_irq,
    output reg         polled
);

    localparam integer PRE_I    = CYC_PER_US - 1;
    localparam [15:0]  PRE_LAST = PRE_I[15:0];

    reg  [31:0] pend_cnt;
    reg  [15:0] us_pre;
    reg  [31:0] us_cnt;
    reg         armed;
    wire [31:0] next_pend;
    wire        is_polled;
    wire        count_hit;
    wire        time_hit;
    wire        fire;

    // ------------------------------
    // Fire conditions
    // ------------------------------
    assign next_pend = pend_cnt + {31'h00000000, event_in};
    // R19: both zero means polled mode
    assign is_polled = (delay_us == 32'h00000000) && (count == 32'h00000000);
    // R15: count reached; one passes every event at once
    assign count_hit = (count != 32'h00000000) && event_in &&
                       (next_pend >= count);
    // R14: zero delay never fires on time
    assign time_hit  = (delay_us != 32'h00000000) && armed &&
                       (us_cnt >= delay_us);
    // R16: whichever comes first
    assign fire = !is_polled && (count_hit || time_hit);

    // ------------------------------
    // Counters and output pulse
    // ------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            host_irq <= 1'b0;
            polled   <= 1'b0;
            pend_cnt <= 32'h00000000;
            us_pre   <= 16'h0000;
            us_cnt   <= 32'h00000000;
            armed    <= 1'b0;
        end else begin
            host_irq <= fire;
            polled   <= is_polled;
            if (fire || is_polled) begin
                // Polled mode drops events; host reads status itself
                pend_cnt <= 32'h00000000;
                armed    <= 1'b0;
                us_pre   <= 16'h0000;
                us_cnt   <= 32'h00000000;
            end else if (event_in && !armed) begin
                pend_cnt <= next_pend;
                armed    <= 1'b1;
                us_pre   <= 16'h0000;
                us_cnt   <= 32'h00000000;
            end else begin
                pend_cnt <= next_pend;
                if (armed) begin
                    if (us_pre == PRE_LAST) begin
                        us_pre <= 16'h0000;
                        us_cnt <= us_cnt + 32'h00000001;
                    end else begin
                        us_pre <= us_pre + 16'h0001;
                    end
                end
            end
        end
    end

endmodule

// [cth_top.v]
// Configuration table, locator words and doorbell handshake of the controller
`timescale 1ns/10ps
`include "cth_defs.vh"

// Behaviour
// R01: Host finds the table by reading locator words at 0xB4 and 0xB8.
// R02: Selector word: config offset in low 16 bits, width id in high.
// R03: Memory offset word gives table byte offset from selected base.
// R04: Host waits for the ready point before using the table.
// R05: Host leaves controller-owned fields alone; no hardware protection exists. Here host writes to those fields are ignored.
// R06: Host rings doorbell bit 0 after updating its table fields.
// R07: Host polls doorbell; controller clears bit 0 after processing.
// R08: After the clear, the controller runs on the new configuration.
// R09: Table offset 04 holds the interface version number.
// R10: Offset 08: bit 0 ready, bit 1 simple method, rest reserved.
// R11: Offset 0C reports the active transport method.
// R12: Host requests a transport method at offset 10.
// R13: Offset 14 holds upper address of the command region; controller uses it.
// R14: Offset 18 is coalescing delay in microseconds; zero disables it.
// R15: Offset 1C is coalescing count; zero disables, one passes all.
// R16: Interrupt passes when delay or count condition is met first.
// R17: Coalescing delay resets to zero.
// R18: Coalescing count resets to one.
// R19: Both coalescing fields zero means polled mode, no host interrupts.
// R20: Offset 20 reports maximum outstanding commands.
// R21: Host ones on doorbell at 0x20 interrupt controller; reads show pending.
// R22: Controller clears doorbell bits by writing ones at 0x70.
// R23: Apply requested method and update active field before clearing bit 0.
module cth_top #(
    parameter [31:0] SIGNATURE     = 32'h5441424C,  // Arbitrary value
    parameter [31:0] VERSION       = 32'h00000001,
    parameter [15:0] SEL_CFG_OFF   = 16'h0014,
    parameter [15:0] SEL_WIDTH_ID  = 16'h0000,
    parameter [31:0] MEM_OFFSET    = 32'h00000000,
    parameter [31:0] MAX_OUTST     = 32'h00000040,
    parameter        SIMPLE_OK     = 1,
    parameter        DB_WIDTH      = 32
) (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        host_rd,
    input  wire        host_wr,
    input  wire        host_table,
    input  wire [7:0]  host_addr,
    input  wire [31:0] host_wdata,
    output reg  [31:0] host_rdata,
    output reg         host_rvalid,
    input  wire        ctl_ready,
    input  wire        ctl_clr_wr,
    input  wire [7:0]  ctl_clr_addr,
    input  wire [31:0] ctl_clr_data,
    input  wire        ctl_event,
    output wire        ctl_doorbell_irq,
    output wire        host_irq,
    output wire        polled_mode,
    output reg  [31:0] cur_method,
    output reg  [31:0] cur_cmd_upper,
    output reg         cfg_update_done
);

    // ------------------------------
    // States of the table update handshake
    // ------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_APPLY = 3'b010;
    localparam [2:0] ST_CLEAR = 3'b100;

    reg  [2:0]          state;
    reg  [2:0]          next_state;
    reg  [31:0]         requested_method;
    reg  [31:0]         command_region_upper_address;
    reg  [31:0]         coalesce_delay_us;
    reg  [31:0]         coalesce_count;
    reg  [31:0]         active_method;
    reg  [31:0]         applied_delay;
    reg  [31:0]         applied_count;
    reg  [31:0]         next_rdata;
    reg  [31:0]         next_method;
    wire [31:0]         supported_methods;
    wire [DB_WIDTH-1:0] db_pending;
    wire [DB_WIDTH-1:0] db_clr_mask;
    wire [DB_WIDTH-1:0] fsm_clr;
    wire                tbl_wr;
    wire                msg_wr;
    wire                db_set_wr;

    // ------------------------------
    // Decode of host writes
    // ------------------------------
    // Shared strobe, two spaces
    assign tbl_wr    = host_wr && host_table;
    assign msg_wr    = host_wr && !host_table;
    // R06: host doorbell ring
    assign db_set_wr = msg_wr && (host_addr == `CTH_OFF_DOORBELL);

    // R10: ready and method support bits, others reserved zero
    assign supported_methods = {30'h00000000,
                                (SIMPLE_OK != 0),
                                ctl_ready};

    // ------------------------------
    // Host-owned table fields
    // ------------------------------
    // R05: controller fields have no host write path here
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            requested_method             <= `CTH_RST_REQUESTED;
            command_region_upper_address <= `CTH_RST_CMD_UPPER;
            // R17: delay resets to zero
            coalesce_delay_us            <= `CTH_RST_DELAY;
            // R18: count resets to one
            coalesce_count               <= `CTH_RST_COUNT;
        end else if (tbl_wr) begin
            case (host_addr)
                // R12: method request
                `CTH_OFF_REQUESTED: begin
                    requested_method <= host_wdata;
                end
                // R13: command region upper bits
                `CTH_OFF_CMD_UPPER: begin
                    command_region_upper_address <= host_wdata;
                end
                // R14: delay field
                `CTH_OFF_DELAY: begin
                    coalesce_delay_us <= host_wdata;
                end
                // R15: count field
                `CTH_OFF_COUNT: begin
                    coalesce_count <= host_wdata;
                end
                default: begin
                    requested_method <= requested_method;
                end
            endcase
        end
    end

    // ------------------------------
    // Handshake state machine
    // ------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // Wait for ready so a ring before init is not lost
                if (db_pending[`CTH_BIT_TABLE_DB] && ctl_ready) begin
                    next_state = ST_APPLY;
                end
            end
            ST_APPLY: begin
                next_state = ST_CLEAR;
            end
            ST_CLEAR: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // Method chosen from the request; unsupported requests keep the old one
    always @* begin
        next_method = active_method;
        if (requested_method[`CTH_BIT_SIMPLE] && (SIMPLE_OK != 0)) begin
            next_method = 32'h00000002;
        end
    end

    // State register
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------
    // Applied configuration
    // ------------------------------
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            active_method   <= `CTH_RST_ACTIVE;
            applied_delay   <= `CTH_RST_DELAY;
            applied_count   <= `CTH_RST_COUNT;
            cur_method      <= `CTH_RST_ACTIVE;
            cur_cmd_upper   <= `CTH_RST_CMD_UPPER;
            cfg_update_done <= 1'b0;
        end else begin
            cfg_update_done <= (state == ST_CLEAR);
            if (state == ST_APPLY) begin
                // R23: apply and report before the clear
                active_method <= next_method;
                // R08: new configuration takes effect
                cur_method    <= next_method;
                // R13: controller uses the region
                cur_cmd_upper <= command_region_upper_address;
                applied_delay <= coalesce_delay_us;
                applied_count <= coalesce_count;
            end
        end
    end

    // ------------------------------
    // Doorbell clear sources
    // ------------------------------
    // R07: controller clears bit 0 once processed
    assign fsm_clr = {{(DB_WIDTH-1){1'b0}}, (state == ST_CLEAR)};
    // R22: firmware clear writes at 0x70
    assign db_clr_mask = fsm_clr |
        ((ctl_clr_wr && (ctl_clr_addr == `CTH_OFF_DB_CLEAR)) ?
         ctl_clr_data[DB_WIDTH-1:0] : {DB_WIDTH{1'b0}});

    // Set wins over a same-cycle clear
    cth_doorbell #(
        .WIDTH    (DB_WIDTH)
    ) u_doorbell (
        .clk_sys  (clk_sys),
        .resetn   (resetn),
        .set_wr   (db_set_wr),
        .set_mask (host_wdata[DB_WIDTH-1:0]),
        .clr_mask (db_clr_mask),
        .pending  (db_pending),
        .ctl_irq  (ctl_doorbell_irq)
    );

    // ------------------------------
    // Host interrupt coalescing on the applied values
    // ------------------------------
    // Live writes wait for the next ring
    cth_coalesce #(
        .CYC_PER_US (`CTH_CYC_PER_US)
    ) u_coalesce (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .event_in   (ctl_event),
        .delay_us   (applied_delay),
        .count      (applied_count),
        .host_irq   (host_irq),
        .polled     (polled_mode)
    );

    // ------------------------------
    // Read data selection
    // ------------------------------
    always @* begin
        next_rdata = 32'h00000000;
        if (host_table) begin
            case (host_addr)
                `CTH_OFF_SIGNATURE: next_rdata = SIGNATURE;
                // R09: version word
                `CTH_OFF_VERSION:   next_rdata = VERSION;
                // R10: supported methods and readiness
                `CTH_OFF_SUPPORTED: next_rdata = supported_methods;
                // R11: active method
                `CTH_OFF_ACTIVE:    next_rdata = active_method;
                `CTH_OFF_REQUESTED: next_rdata = requested_method;
                `CTH_OFF_CMD_UPPER: next_rdata = command_region_upper_address;
                `CTH_OFF_DELAY:     next_rdata = coalesce_delay_us;
                `CTH_OFF_COUNT:     next_rdata = coalesce_count;
                // R20: outstanding command limit
                `CTH_OFF_MAX_OUTST: next_rdata = MAX_OUTST;
                default:            next_rdata = 32'h00000000;
            endcase
        end else begin
            case (host_addr)
                // R21: pending doorbell bits
                `CTH_OFF_DOORBELL: begin
                    next_rdata = {{(32-DB_WIDTH){1'b0}}, db_pending};
                end
                // R02: selector word layout
                `CTH_OFF_LOC_SEL: begin
                    next_rdata = {SEL_WIDTH_ID, SEL_CFG_OFF};
                end
                // R03: table byte offset
                `CTH_OFF_MEM_OFFSET: begin
                    next_rdata = MEM_OFFSET;
                end
                // Clear register is controller-only, reads zero
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    // Read answer one cycle after the request
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            host_rdata  <= 32'h00000000;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_rd;
            if (host_rd) begin
                host_rdata <= next_rdata;
            end
        end
    end

endmodule

// [cth_top_assertions.sv]
// Port checker of the configuration table block
`timescale 1ns/10ps
module cth_checker #(
    parameter [31:0] VERSION      = 32'h00000001,
    parameter [15:0] SEL_CFG_OFF  = 16'h0014,
    parameter [15:0] SEL_WIDTH_ID = 16'h0000,
    parameter [31:0] MAX_OUTST    = 32'h00000040
) (
    input wire        clk_sys, resetn, host_rd, host_wr, host_table,
    input wire [7:0]  host_addr, ctl_clr_addr,
    input wire [31:0] host_wdata, host_rdata, ctl_clr_data,
    input wire        host_rvalid, ctl_ready, ctl_clr_wr, ctl_event,
    input wire        ctl_doorbell_irq, host_irq, polled_mode,
    input wire [31:0] cur_method, cur_cmd_upper,
    input wire        cfg_update_done
);
    // Host request decodes
    wire tab_rd = host_rd && host_table;
    wire msg_rd = host_rd && !host_table;
    wire db_wr  = host_wr && !host_table && host_addr == 8'h20;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Read answers
    // ----------------------------------------
    read_answer_a: assert property (host_rd |=> host_rvalid)
        else $error("read not answered after one cycle");
    version_word_a: assert property (
        tab_rd && host_addr == 8'h04 |=> host_rdata == VERSION)
        else $error("version word wrong");
    selector_word_a: assert property (
        msg_rd && host_addr == 8'hB4 |=>
        host_rdata == {SEL_WIDTH_ID, SEL_CFG_OFF})
        else $error("selector word wrong");
    max_outst_a: assert property (
        tab_rd && host_addr == 8'h20 |=> host_rdata == MAX_OUTST)
        else $error("outstanding limit word wrong");
    ready_bit_a: assert property (
        tab_rd && host_addr == 8'h08 |=> host_rdata[0] ==
        $past(ctl_ready) && host_rdata[31:2] == 30'h0)
        else $error("supported word wrong");

    // ----------------------------------------
    // Doorbell, handshake and polled mode
    // ----------------------------------------
    db_raise_a: assert property (
        db_wr && host_wdata != 32'h0 |-> ##2 ctl_doorbell_irq)
        else $error("doorbell did not interrupt controller");
    db_clear_a: assert property (
        ctl_clr_wr && ctl_clr_addr == 8'h70 && (&ctl_clr_data) &&
        !host_wr |-> ##2 !ctl_doorbell_irq)
        else $error("doorbell clear did not act");
    ring_done_a: assert property (
        db_wr && host_wdata[0] && ctl_ready |-> ##4 cfg_update_done)
        else $error("table update not completed in time");
    method_done_a: assert property (
        cur_method != $past(cur_method) |=> cfg_update_done)
        else $error("method changed outside a handshake");
    polled_quiet_a: assert property (polled_mode |-> !host_irq)
        else $error("host interrupt in polled mode");

    cover property (cfg_update_done);
    cover property (host_irq);
    cover property (polled_mode && ctl_event);
endmodule

bind cth_top cth_checker #(
    .VERSION(VERSION), .SEL_CFG_OFF(SEL_CFG_OFF),
    .SEL_WIDTH_ID(SEL_WIDTH_ID), .MAX_OUTST(MAX_OUTST)
) i_chk (.*);

// [cth_host_model.sv]
// Host driver model: word reads, writes and doorbell polls
`timescale 1ns/10ps
module cth_host_model (
    input  wire        clk_sys,
    input  wire [31:0] host_rdata,
    input  wire        host_rvalid,
    output reg         host_rd,
    output reg         host_wr,
    output reg         host_table,
    output reg  [7:0]  host_addr,
    output reg  [31:0] host_wdata
);
    integer timeouts = 0;

    initial {host_rd, host_wr, host_table, host_addr, host_wdata} = 43'h0;

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // One request cycle; released lines invert so stale data never helps
    task req(input r, input t, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            #1;
            {host_rd, host_wr, host_table, host_addr, host_wdata} =
                {r, ~r, t, a, d};
            @(posedge clk_sys);
            #1;
            {host_rd, host_wr, host_addr, host_wdata} = {2'b00, ~a, ~d};
        end
    endtask

    task wr(input t, input [7:0] a, input [31:0] d);
        req(1'b0, t, a, d);
    endtask

    // word read, bounded wait for the answer
    task rd(input t, input [7:0] a, output [31:0] d);
        integer n;
        begin
            req(1'b1, t, a, 32'h00000000);
            for (n = 0; n < 4 && host_rvalid !== 1'b1; n = n + 1)
                @(posedge clk_sys) #1;
            if (host_rvalid !== 1'b1)
                timeouts = timeouts + 1;
            d = host_rdata;
        end
    endtask

    // poll bit 0 until it shows the awaited level
    task poll(input t, input [7:0] a, input v);
        reg [31:0] d;
        integer    n;
        begin
            d = {32{~v}};
            for (n = 0; n < 50 && d[0] !== v; n = n + 1)
                rd(t, a, d);
            if (d[0] !== v)
                timeouts = timeouts + 1;
        end
    endtask

    // announce a table update and wait for its clear
    task ring;
        begin
            wr(1'b0, 8'h20, 32'h00000001);
            poll(1'b0, 8'h20, 1'b0);
        end
    endtask
endmodule

// [tb_top.sv]
// Self-checking bench of the configuration table block
`timescale 1ns/10ps
module tb_top;
    localparam [31:0] VER  = 32'h00000003;
    localparam [15:0] CFGO = 16'h0010;
    localparam [15:0] WID  = 16'h0001;
    localparam [31:0] MOFF = 32'h00004000;
    localparam [31:0] MAXO = 32'h00000010;
    localparam [31:0] SIG  = 32'h1357ACE0;  // Arbitrary

    reg         clk_sys = 1'b0;
    reg         resetn = 1'b0;
    reg         ctl_ready = 1'b0;
    reg         ctl_clr_wr = 1'b0;
    reg         ctl_event = 1'b0;
    reg  [7:0]  ctl_clr_addr = 8'h00;
    reg  [31:0] ctl_clr_data = 32'h00000000;
    reg  [31:0] rdat;
    wire        host_rd, host_wr, host_table, host_rvalid;
    wire        ctl_doorbell_irq, host_irq, polled_mode, cfg_update_done;
    wire [7:0]  host_addr;
    wire [31:0] host_wdata, host_rdata, cur_method, cur_cmd_upper;
    integer     miscompares = 0;
    integer     n_checks = 0;
    integer     irq_cnt = 0;
    integer     base;

    always #2.5 clk_sys = ~clk_sys;

    // Tally passed host interrupts, one per pulse
    always @(posedge clk_sys)
        if (host_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;

    cth_top #(
        .VERSION(VER), .SEL_CFG_OFF(CFGO), .SEL_WIDTH_ID(WID),
        .MEM_OFFSET(MOFF), .MAX_OUTST(MAXO), .SIGNATURE(SIG)
    ) i_dut (.*);

    cth_host_model i_host (.*);

    // ----------------------------------------
    // Checks and controller-side stimulus
    // ----------------------------------------
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                $display("Error %s expected %h seen %h", nm, e, g);
                miscompares = miscompares + 1;
            end
        end
    endtask

    task rchk(input t, input [7:0] a, input [31:0] e, input string nm);
        begin
            i_host.rd(t, a, rdat);
            chk(nm, e, rdat);
        end
    endtask

    // One controller strobe, then a cycle for its effect to land
    task ctl(input e, input c, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            #1;
            {ctl_event, ctl_clr_wr, ctl_clr_addr, ctl_clr_data} = {e, c, a, d};
            @(posedge clk_sys);
            #1;
            {ctl_event, ctl_clr_wr} = 2'b00;
            @(posedge clk_sys) #1;
        end
    endtask

    // host fields, then the doorbell handshake
    task cfg(input [31:0] dl, input [31:0] ct, input [31:0] up);
        begin
            i_host.wr(1'b1, 8'h10, 32'h00000002);
            i_host.wr(1'b1, 8'h14, up);
            i_host.wr(1'b1, 8'h18, dl);
            i_host.wr(1'b1, 8'h1C, ct);
            i_host.ring;
        end
    endtask

    task stop_test;
        begin
            miscompares = miscompares + i_host.timeouts;
            if (miscompares == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // Main sequence: defaults, locator, handshake, coalescing, doorbell
    initial begin
        repeat (20) @(posedge clk_sys);
        #1;
        resetn = 1'b1;
        rchk(1'b1, 8'h00, SIG, "signature");
        rchk(1'b1, 8'h18, 32'h00000000, "delay");
        rchk(1'b1, 8'h1C, 32'h00000001, "count");
        rchk(1'b1, 8'h0C, 32'h00000000, "active");
        rchk(1'b0, 8'hB4, {WID, CFGO}, "selector");
        rchk(1'b0, 8'hB8, MOFF, "mem_offset");
        rchk(1'b1, 8'h20, MAXO, "max_outst");
        rchk(1'b1, 8'h08, 32'h00000002, "supported");
        // Controller-owned words ignore host writes
        i_host.wr(1'b1, 8'h04, 32'hFFFFFFFF);
        i_host.wr(1'b0, 8'hB4, 32'hFFFFFFFF);
        rchk(1'b1, 8'h04, VER, "version");
        rchk(1'b0, 8'hB4, {WID, CFGO}, "selector");
        rchk(1'b0, 8'h44, 32'h00000000, "unmapped");
        // A ring before the ready point stays pending
        i_host.wr(1'b0, 8'h20, 32'h00000001);
        repeat (8) @(posedge clk_sys);
        rchk(1'b0, 8'h20, 32'h00000001, "doorbell");
        ctl_ready = 1'b1;
        i_host.poll(1'b1, 8'h08, 1'b1);
        i_host.poll(1'b0, 8'h20, 1'b0);
        rchk(1'b1, 8'h08, 32'h00000003, "supported");
        cfg(32'h0, 32'h1, 32'h89ABCDEF);
        rchk(1'b1, 8'h0C, 32'h00000002, "active");
        chk("cur_method", 32'h00000002, cur_method);
        chk("cmd_upper", 32'h89ABCDEF, cur_cmd_upper);
        base = irq_cnt;
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        chk("irq_count1", base + 1, irq_cnt);
        cfg(32'h0, 32'h3, 32'h0);
        base = irq_cnt;
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        chk("irq_count3a", base, irq_cnt);
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        chk("irq_count3b", base + 1, irq_cnt);
        cfg(32'h0, 32'h0, 32'h0);
        chk("polled", 32'h1, {31'h0, polled_mode});
        base = irq_cnt;
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        chk("irq_polled", base, irq_cnt);
        // One microsecond is 200 cycles; the timer fires near 202
        cfg(32'h1, 32'h0, 32'h0);
        base = irq_cnt;
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        repeat (150) @(posedge clk_sys);
        chk("irq_early", base, irq_cnt);
        repeat (100) @(posedge clk_sys);
        chk("irq_delay", base + 1, irq_cnt);
        cfg(32'h1, 32'h2, 32'h0);
        base = irq_cnt;
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        ctl(1'b1, 1'b0, 8'h00, 32'h0);
        chk("irq_first", base + 1, irq_cnt);
        i_host.wr(1'b0, 8'h20, 32'h00000004);
        rchk(1'b0, 8'h20, 32'h00000004, "doorbell");
        chk("db_irq", 32'h1, {31'h0, ctl_doorbell_irq});
        ctl(1'b0, 1'b1, 8'h74, 32'h00000004);
        rchk(1'b0, 8'h20, 32'h00000004, "doorbell");
        ctl(1'b0, 1'b1, 8'h70, 32'hFFFFFFFF);
        rchk(1'b0, 8'h20, 32'h00000000, "doorbell");
        stop_test;
    end
endmodule
